/* rtl/pm_cfg.svh */
`ifndef PM_CFG_SVH
`define PM_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define L0S_IDLE_US 6
`define L0S_IDLE_CYC ((`L0S_IDLE_US * 1000) / `CLK_PERIOD_NS)
`define WAKE_SAMPLE_US 100
`define WAKE_SAMPLE_CYC ((`WAKE_SAMPLE_US * 1000) / `CLK_PERIOD_NS)
`define L1_LINGER_CYC 16
`define EXIT_CYC 4
`define CNT_W 16

// ----------------------------------------
// Configuration selects and fields
// ----------------------------------------
`define CFG_CMD 2'h0
`define CFG_PMCSR 2'h1
`define CFG_LNKCTL 2'h2
`define CFG_LNKCAP 2'h3
`define PS_D0 2'h0
`define PS_D3HOT 2'h3
`define PMCSR_NSR_BIT 3
`define LNKCTL_L0S_BIT 0
`define LNKCAP_VAL 8'h01
`define CMD_RESET 3'h0
`define LNKCTL_RESET 2'h0
`define CLKOUT_ON 2'h3
`define CLKOUT_OFF 2'h0

`endif

/* rtl/pm_pkg.sv */
package pm_pkg;
  typedef enum logic [2:0] {
    PKT_TLP = 3'h0,
    PKT_DLLP = 3'h1,
    PKT_PME = 3'h2,
    PKT_TO_ACK = 3'h3,
    PKT_ENTER_L1 = 3'h4
  } pkt_e;
  typedef enum logic [1:0] {
    RX_TLP = 2'h0,
    RX_TURN_OFF = 2'h1
  } rxkind_e;
  typedef enum logic [2:0] {
    LS_L0 = 3'h0,
    LS_L0S = 3'h1,
    LS_L1 = 3'h2,
    LS_L23 = 3'h3,
    LS_EXIT = 3'h4,
    LS_LINK_DOWN = 3'h5
  } link_e;
  typedef enum logic [1:0] {
    DS_D0_UNINIT = 2'h0,
    DS_D0_ACTIVE = 2'h1,
    DS_D3HOT = 2'h2
  } dstate_e;
  typedef enum logic {
    H_IDLE = 1'h0,
    H_WAKE = 1'h1
  } host_e;
endpackage

/* rtl/pm_link_if.sv */
interface pm_link_if;
  import pm_pkg::*;
  logic txValid;
  pkt_e txKind;
  link_e devLink;
  logic cfgRdValid;
  logic [7:0] cfgRdData;
  logic rxValid;
  rxkind_e rxKind;
  logic cfgWr;
  logic cfgRd;
  logic [1:0] cfgSel;
  logic [7:0] cfgData;
  logic exitReq;
  logic hostStandby;
  modport dev (
    output txValid, txKind, devLink, cfgRdValid, cfgRdData,
    input rxValid, rxKind, cfgWr, cfgRd, cfgSel, cfgData, exitReq, hostStandby
  );
  modport host (
    input txValid, txKind, devLink, cfgRdValid, cfgRdData,
    output rxValid, rxKind, cfgWr, cfgRd, cfgSel, cfgData, exitReq, hostStandby
  );
endinterface

/* rtl/idle_timer.sv */
`include "pm_cfg.svh"
module idle_timer import pm_pkg::*; #(
  parameter int unsigned LIMIT = 60
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic enable,
  input wire logic restart,
  output logic expired
);
  logic [`CNT_W-1:0] count;
  logic [`CNT_W-1:0] next_count;

  // Expires once idle strictly longer than LIMIT cycles
  assign expired = count > `CNT_W'(LIMIT);
  assign next_count = (!enable || restart) ? '0 : (expired ? count : count + 1'b1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) count <= '0;
    else count <= next_count;
  end
endmodule

/* rtl/power_manager_dev.sv */
// Function
// - Standby entry off after reset
// - Idle over 6 us enters transmit standby
// - Pending packets start standby exit
// - Traffic from either side wakes standby
// - No packets sent while in standby
// - Own standby independent of partner's standby
// - Idle timing never enters L1
// - Host reads capability before enabling standby
// - D3hot write starts L1 entry
// - No packets in L1; either side exits
// - Turn-off answered with ack, then L2/L3 Ready
// - L2/L3 Ready: silent, wake ignored
// - No L2; only power removal follows
// - Enable bits move D0 uninitialized to active
// - Config accesses answered in D3hot
// - D3hot to D0 sets no-soft-reset bit
// - Cold reset gives D0 uninitialized, context lost
// - D-state only by field; no D1/D2
// - Link returned to L0 before PME
// - Wake pin sampled every 100 us
// - D3hot keeps clocks, reset released, no transactions
// - Standby enabled only by link control field
`include "pm_cfg.svh"
module power_manager_dev import pm_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  pm_link_if.dev link,
  input wire logic txReq,
  input wire logic txIsDllp,
  input wire logic pciActive,
  input wire logic wakeReq_n,
  output logic txTake,
  output logic rxTlp,
  output logic [1:0] secClockEnable,
  output logic secBusReset_n,
  output logic busTxnAllowed,
  output link_e linkState,
  output dstate_e powerState
);
  link_e lState;
  link_e next_lState;
  dstate_e dState;
  dstate_e next_dState;
  logic [2:0] cmd;
  logic [1:0] standbyField;
  logic noSoftReset;
  logic ackPending;
  logic pmePending;
  logic [`CNT_W-1:0] exitCnt;
  logic [`CNT_W-1:0] sampleCnt;
  logic wakeSync1;
  logic wakeSync2;
  logic wakeSeen;
  logic txValid;
  pkt_e txKind;
  logic [7:0] rdData;
  logic rdValid;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic standbyOn, isD3, inL0, inL23, rxActivity, devPending;
  logic cfgWrCmd, cfgWrPm, cfgWrCtl, psWrD3, psWrD0, anyEnable;
  logic sendAck, sendPme, sendUser, sendL1, enterL0s, txSent;
  logic l0sExpired, l1Expired, exitDone, sampleTick, newWake, turnOff;
  logic [7:0] rdMux;
  logic [1:0] psField;

  assign standbyOn = standbyField[`LNKCTL_L0S_BIT];
  assign isD3 = dState == DS_D3HOT;
  assign inL0 = lState == LS_L0;
  assign inL23 = lState == LS_L23;
  assign rxActivity = link.rxValid | link.cfgWr | link.cfgRd | pciActive;
  assign devPending = txReq | pmePending | ackPending;
  assign cfgWrCmd = link.cfgWr & (link.cfgSel == `CFG_CMD);
  assign cfgWrPm = link.cfgWr & (link.cfgSel == `CFG_PMCSR);
  assign cfgWrCtl = link.cfgWr & (link.cfgSel == `CFG_LNKCTL);
  assign psWrD3 = cfgWrPm & (link.cfgData[1:0] == `PS_D3HOT);
  assign psWrD0 = cfgWrPm & (link.cfgData[1:0] == `PS_D0);
  assign anyEnable = |cmd;
  assign turnOff = link.rxValid & (link.rxKind == RX_TURN_OFF);

  // ----------------------------------------
  // Transmit arbitration, only in L0
  // ----------------------------------------
  assign sendAck = inL0 & ackPending;
  assign sendPme = inL0 & !ackPending & pmePending;
  assign sendUser = inL0 & !ackPending & !pmePending & txReq;
  assign sendL1 = inL0 & !devPending & isD3 & l1Expired;
  assign enterL0s = inL0 & !devPending & !isD3 & standbyOn & l0sExpired;
  assign txSent = sendAck | sendPme | sendUser | sendL1;
  assign txTake = sendUser;
  assign exitDone = exitCnt == `CNT_W'(`EXIT_CYC - 1);

  idle_timer #(.LIMIT(`L0S_IDLE_CYC)) standbyTimer (
    .clk(clk),
    .arst_n(arst_n),
    .enable(standbyOn),
    .restart(txSent | !inL0),
    .expired(l0sExpired)
  );

  idle_timer #(.LIMIT(`L1_LINGER_CYC)) lingerTimer (
    .clk(clk),
    .arst_n(arst_n),
    .enable(isD3),
    .restart(txSent | rxActivity | !inL0),
    .expired(l1Expired)
  );

  // ----------------------------------------
  // Link state
  // ----------------------------------------
  always_comb begin
    next_lState = lState;
    unique case (lState)
      LS_LINK_DOWN, LS_EXIT: begin
        if (exitDone) next_lState = LS_L0;
      end
      LS_L0: begin
        if (sendAck) next_lState = LS_L23;
        else if (sendL1) next_lState = LS_L1;
        else if (enterL0s) next_lState = LS_L0S;
      end
      LS_L0S: begin
        if (devPending) next_lState = LS_EXIT;
        else if (rxActivity) next_lState = LS_EXIT;
      end
      LS_L1: begin
        if (devPending || link.exitReq || rxActivity) next_lState = LS_EXIT;
      end
      LS_L23: next_lState = LS_L23;
      default: next_lState = LS_LINK_DOWN;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) lState <= LS_LINK_DOWN;
    else lState <= next_lState;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) exitCnt <= '0;
    else if (lState == LS_EXIT || lState == LS_LINK_DOWN) exitCnt <= exitCnt + 1'b1;
    else exitCnt <= '0;
  end

  // ----------------------------------------
  // Device power state
  // ----------------------------------------
  always_comb begin
    next_dState = dState;
    if (psWrD3) next_dState = DS_D3HOT;
    else if (psWrD0 && isD3) next_dState = DS_D0_UNINIT;
    else if (dState == DS_D0_UNINIT && anyEnable) next_dState = DS_D0_ACTIVE;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) dState <= DS_D0_UNINIT;
    else dState <= next_dState;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd <= `CMD_RESET;
      standbyField <= `LNKCTL_RESET;
      noSoftReset <= 1'b0;
    end else begin
      if (cfgWrCmd) cmd <= link.cfgData[2:0];
      if (cfgWrCtl) standbyField <= link.cfgData[1:0];
      if (psWrD0 && isD3) noSoftReset <= 1'b1;
    end
  end

  // ----------------------------------------
  // Configuration read, answered in every D-state
  // ----------------------------------------
  assign psField = isD3 ? `PS_D3HOT : `PS_D0;
  always_comb begin
    rdMux = 8'h00;
    unique case (link.cfgSel)
      `CFG_CMD: rdMux = {5'h00, cmd};
      `CFG_PMCSR: begin
        rdMux = {6'h00, psField};
        rdMux[`PMCSR_NSR_BIT] = noSoftReset;
      end
      `CFG_LNKCTL: rdMux = {6'h00, standbyField};
      `CFG_LNKCAP: rdMux = `LNKCAP_VAL;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdValid <= 1'b0;
      rdData <= 8'h00;
    end else begin
      rdValid <= link.cfgRd;
      rdData <= rdMux;
    end
  end

  // ----------------------------------------
  // Wake sampling and pending events
  // ----------------------------------------
  assign sampleTick = sampleCnt == `CNT_W'(`WAKE_SAMPLE_CYC - 1);
  assign newWake = sampleTick & !wakeSync2 & !wakeSeen & !inL23;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wakeSync1 <= 1'b1;
      wakeSync2 <= 1'b1;
      sampleCnt <= '0;
      wakeSeen <= 1'b0;
    end else begin
      wakeSync1 <= wakeReq_n;
      wakeSync2 <= wakeSync1;
      sampleCnt <= sampleTick ? '0 : sampleCnt + 1'b1;
      if (sampleTick) wakeSeen <= !wakeSync2;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pmePending <= 1'b0;
      ackPending <= 1'b0;
    end else begin
      pmePending <= newWake | (pmePending & !sendPme);
      ackPending <= (turnOff & !inL23) | (ackPending & !sendAck);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txValid <= 1'b0;
      txKind <= PKT_TLP;
      secClockEnable <= `CLKOUT_OFF;
      secBusReset_n <= 1'b0;
      busTxnAllowed <= 1'b0;
      rxTlp <= 1'b0;
    end else begin
      txValid <= txSent;
      if (sendAck) txKind <= PKT_TO_ACK;
      else if (sendPme) txKind <= PKT_PME;
      else if (sendUser) txKind <= txIsDllp ? PKT_DLLP : PKT_TLP;
      else if (sendL1) txKind <= PKT_ENTER_L1;
      secClockEnable <= inL23 ? `CLKOUT_OFF : `CLKOUT_ON;
      secBusReset_n <= 1'b1;
      busTxnAllowed <= !isD3 & !inL23;
      rxTlp <= link.rxValid & (link.rxKind == RX_TLP);
    end
  end

  // Device standby never looks at the partner's hostStandby
  assign link.txValid = txValid;
  assign link.txKind = txKind;
  assign link.devLink = lState;
  assign link.cfgRdValid = rdValid;
  assign link.cfgRdData = rdData;
  assign linkState = lState;
  assign powerState = dState;
endmodule

/* rtl/upstream_port.sv */
`include "pm_cfg.svh"
module upstream_port import pm_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  pm_link_if.host link,
  input wire logic cfgWrReq,
  input wire logic cfgRdReq,
  input wire logic [1:0] cfgSel,
  input wire logic [7:0] cfgData,
  input wire logic tlpReq,
  input wire logic turnOffReq,
  input wire logic standbyEnable,
  output logic ready,
  output logic rdValid,
  output logic [7:0] rdData,
  output logic pmeSeen,
  output logic ackSeen,
  output logic l1Seen,
  output logic hostStandby
);
  host_e hState;
  host_e next_hState;
  logic capL0s;
  logic lastRdCap;
  logic anyReq, linkUsable, take, doWr, doRd, doOff, doTlp, sentAny;
  logic [7:0] wrData;

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  assign anyReq = cfgWrReq | cfgRdReq | tlpReq | turnOffReq;
  assign linkUsable = (link.devLink == LS_L0) || (link.devLink == LS_L0S);
  assign ready = (hState == H_IDLE) & linkUsable;
  assign take = ready & anyReq;
  assign doWr = take & cfgWrReq;
  assign doRd = take & !cfgWrReq & cfgRdReq;
  assign doOff = take & !cfgWrReq & !cfgRdReq & turnOffReq;
  assign doTlp = take & !cfgWrReq & !cfgRdReq & !turnOffReq & tlpReq;
  assign sentAny = doWr | doRd | doOff | doTlp;

  always_comb begin
    wrData = cfgData;
    if (cfgSel == `CFG_LNKCTL) wrData[`LNKCTL_L0S_BIT] = cfgData[`LNKCTL_L0S_BIT] & capL0s;
  end

  always_comb begin
    next_hState = hState;
    unique case (hState)
      H_IDLE: begin
        if (anyReq && link.devLink == LS_L1) next_hState = H_WAKE;
      end
      H_WAKE: begin
        if (link.devLink == LS_L0) next_hState = H_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // State and outgoing flops
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) hState <= H_IDLE;
    else hState <= next_hState;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link.rxValid <= 1'b0;
      link.rxKind <= RX_TLP;
      link.cfgWr <= 1'b0;
      link.cfgRd <= 1'b0;
      link.cfgSel <= `CFG_CMD;
      link.cfgData <= 8'h00;
      link.exitReq <= 1'b0;
    end else begin
      link.rxValid <= doOff | doTlp;
      link.rxKind <= doOff ? RX_TURN_OFF : RX_TLP;
      link.cfgWr <= doWr;
      link.cfgRd <= doRd;
      if (doWr || doRd) link.cfgSel <= cfgSel;
      if (doWr) link.cfgData <= wrData;
      link.exitReq <= next_hState == H_WAKE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      capL0s <= 1'b0;
      lastRdCap <= 1'b0;
    end else begin
      lastRdCap <= link.cfgRd & (link.cfgSel == `CFG_LNKCAP);
      if (link.cfgRdValid && lastRdCap) capL0s <= link.cfgRdData[`LNKCTL_L0S_BIT];
    end
  end

  // Host transmit standby runs on its own timer
  idle_timer #(.LIMIT(`L0S_IDLE_CYC)) hostTimer (
    .clk(clk),
    .arst_n(arst_n),
    .enable(standbyEnable),
    .restart(sentAny | link.exitReq),
    .expired(hostStandby)
  );

  assign link.hostStandby = hostStandby;
  assign rdValid = link.cfgRdValid;
  assign rdData = link.cfgRdData;
  assign pmeSeen = link.txValid & (link.txKind == PKT_PME);
  assign ackSeen = link.txValid & (link.txKind == PKT_TO_ACK);
  assign l1Seen = link.txValid & (link.txKind == PKT_ENTER_L1);
endmodule

/* testbench/pm_link_properties.sv */
`include "pm_cfg.svh"
module pm_link_properties import pm_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic txValid,
  input pkt_e txKind,
  input link_e devLink,
  input wire logic cfgRdValid,
  input wire logic [7:0] cfgRdData,
  input wire logic rxValid,
  input rxkind_e rxKind,
  input wire logic cfgWr,
  input wire logic cfgRd,
  input wire logic [1:0] cfgSel,
  input wire logic [7:0] cfgData,
  input wire logic hostStandby
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Idle tracking
  // ----------------------------------------
  logic [7:0] idleCnt;
  logic [7:0] next_idleCnt;
  logic standbyOn;
  logic next_standbyOn;
  assign next_idleCnt = (devLink != LS_L0 || txValid) ? 8'h00 : ((idleCnt == 8'hFF) ? idleCnt : idleCnt + 8'h01);
  assign next_standbyOn = (cfgWr && cfgSel == `CFG_LNKCTL) ? cfgData[`LNKCTL_L0S_BIT] : standbyOn;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idleCnt <= 8'h00;
      standbyOn <= 1'b0;
    end else begin
      idleCnt <= next_idleCnt;
      standbyOn <= next_standbyOn;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  AST_NO_TX_L0S: assert property (devLink == LS_L0S |-> !txValid)
    else $error("packet sent in standby");
  AST_STANDBY_ENTRY: assert property ($rose(devLink == LS_L0S) |->
    standbyOn && idleCnt > 8'(`L0S_IDLE_CYC))
    else $error("standby entered without enable or idle time");
  AST_EXIT_BOUND: assert property ($rose(devLink == LS_EXIT) |-> ##[1:6] devLink == LS_L0)
    else $error("exit did not reach L0");
  AST_L1_ENTRY: assert property ($rose(devLink == LS_L1) |-> txValid && txKind == PKT_ENTER_L1)
    else $error("L1 reached without entry message");
  AST_NO_TX_L1: assert property ($past(devLink == LS_L1) && devLink == LS_L1 |-> !txValid)
    else $error("packet sent in L1");
  AST_TURNOFF_ACK: assert property (rxValid && rxKind == RX_TURN_OFF |-> ##[1:40] txValid && txKind == PKT_TO_ACK)
    else $error("turn-off not acknowledged");
  AST_L23_HOLD: assert property ($past(devLink == LS_L23) |-> devLink == LS_L23 && !txValid)
    else $error("L2/L3 Ready left or not silent");
  AST_PME_FROM_L0: assert property (txValid && txKind == PKT_PME |-> $past(devLink) == LS_L0)
    else $error("PME sent outside L0");
  AST_CFG_ANSWER: assert property (cfgRd |=> cfgRdValid)
    else $error("config read not answered");
  AST_LNKCAP: assert property (cfgRd && cfgSel == `CFG_LNKCAP |=> cfgRdData == `LNKCAP_VAL)
    else $error("link capability value wrong");
  cover property ($rose(devLink == LS_L0S));
  cover property ($rose(devLink == LS_L1));
  cover property (txValid && txKind == PKT_PME);
  cover property (txValid && txKind == PKT_TO_ACK);
  cover property (devLink == LS_L0S && !hostStandby);
endmodule

/* testbench/pcie_bridge_power_manager_test.sv */
`include "pm_cfg.svh"
module pcie_bridge_power_manager_test import pm_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, arst_n = 1'b0, cfgWrReq = 1'b0, cfgRdReq = 1'b0, tlpReq = 1'b0, turnOffReq = 1'b0;
  logic standbyEnable = 1'b0, txReq = 1'b0, txIsDllp = 1'b0, pciActive = 1'b0, wakeReq_n = 1'b1;
  logic [1:0] cfgSel = 2'h0;
  logic [7:0] cfgData = 8'h00;
  logic [1:0] secClockEnable;
  logic [7:0] rdData;
  logic ready, rdValid, pmeSeen, ackSeen, l1Seen, txTake, rxTlp, secBusReset_n, busTxnAllowed, hostStandby;
  link_e linkState;
  dstate_e powerState;
  int errCount = 0, numChecks = 0, cyc = 0;
  pm_link_if lnk();
  power_manager_dev power_manager_dev_i (.clk(clk), .arst_n(arst_n), .link(lnk), .txReq(txReq), .txIsDllp(txIsDllp),
    .pciActive(pciActive), .wakeReq_n(wakeReq_n), .txTake(txTake), .rxTlp(rxTlp), .secClockEnable(secClockEnable),
    .secBusReset_n(secBusReset_n), .busTxnAllowed(busTxnAllowed), .linkState(linkState), .powerState(powerState));
  upstream_port upstream_port_i (.clk(clk), .arst_n(arst_n), .link(lnk), .cfgWrReq(cfgWrReq), .cfgRdReq(cfgRdReq),
    .cfgSel(cfgSel), .cfgData(cfgData), .tlpReq(tlpReq), .turnOffReq(turnOffReq), .standbyEnable(standbyEnable),
    .ready(ready), .rdValid(rdValid), .rdData(rdData), .pmeSeen(pmeSeen), .ackSeen(ackSeen), .l1Seen(l1Seen),
    .hostStandby(hostStandby));
  pm_link_properties pm_link_properties_i (.clk(clk), .arst_n(arst_n), .txValid(lnk.txValid), .txKind(lnk.txKind),
    .devLink(lnk.devLink), .cfgRdValid(lnk.cfgRdValid), .cfgRdData(lnk.cfgRdData), .rxValid(lnk.rxValid),
    .rxKind(lnk.rxKind), .cfgWr(lnk.cfgWr), .cfgRd(lnk.cfgRd), .cfgSel(lnk.cfgSel), .cfgData(lnk.cfgData),
    .hostStandby(lnk.hostStandby));
  always #50 clk = ~clk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic conclude;
    if (errCount == 0 && numChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      errCount++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    numChecks++;
    if (g !== e) begin
      errCount++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Kinds: 0 write, 1 read, 2 turn-off, 3 TLP
  task automatic hostOp(input int k, input logic [1:0] s, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cfgSel <= s;
    cfgData <= d;
    cfgWrReq <= (k == 0);
    cfgRdReq <= (k == 1);
    turnOffReq <= (k == 2);
    tlpReq <= (k == 3);
    do begin
      @(negedge clk);
      n++;
    end while (!ready && n < 400);
    chk("ready", 8'h01, 8'(ready));
    @(posedge clk);
    {cfgWrReq, cfgRdReq, turnOffReq, tlpReq} <= 4'h0;
  endtask
  task automatic readChk(input logic [1:0] s, input logic [7:0] e, input string nm);
    hostOp(1, s, 8'h00);
    @(posedge clk);
    @(negedge clk);
    chk("rdValid", 8'h01, 8'(rdValid));
    chk(nm, e, rdData);
  endtask
  task automatic waitLink(input link_e s, input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (linkState !== s && n < lim);
    chk("linkState", 8'(s), 8'(linkState));
  endtask
  task automatic sendPkt(input logic dllp);
    int n;
    n = 0;
    @(posedge clk);
    txReq <= 1'b1;
    txIsDllp <= dllp;
    do begin
      @(negedge clk);
      n++;
    end while (!txTake && n < 20);
    @(posedge clk);
    txReq <= 1'b0;
    @(negedge clk);
    chk("txKind", dllp ? 8'(PKT_DLLP) : 8'(PKT_TLP), 8'(lnk.txKind));
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic doReset;
    int n;
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("powerState", 8'(DS_D0_UNINIT), 8'(powerState));
    chk("secBusReset_n", 8'h00, 8'(secBusReset_n));
    @(posedge clk);
    arst_n <= 1'b1;
    waitLink(LS_L0, 20, n);
    chk("secClockEnable", 8'(`CLKOUT_ON), 8'(secClockEnable));
    chk("busTxnAllowed", 8'h01, 8'(busTxnAllowed));
    readChk(`CFG_PMCSR, 8'h00, "pmcsr");
    readChk(`CFG_LNKCTL, 8'h00, "lnkctl");
  endtask
  task automatic initCfg;
    hostOp(0, `CFG_CMD, 8'h02);
    repeat (3) @(negedge clk);
    chk("powerState", 8'(DS_D0_ACTIVE), 8'(powerState));
    hostOp(0, `CFG_PMCSR, 8'h01);
    repeat (3) @(negedge clk);
    chk("powerState", 8'(DS_D0_ACTIVE), 8'(powerState));
    readChk(`CFG_PMCSR, 8'h00, "pmcsr");
    readChk(`CFG_CMD, 8'h02, "cmd");
    sendPkt(1'b0);
  endtask
  task automatic standby;
    int n;
    readChk(`CFG_LNKCAP, `LNKCAP_VAL, "lnkcap");
    hostOp(0, `CFG_LNKCTL, 8'h01);
    waitLink(LS_L0S, 100, n);
    chk("hostStandby", 8'h00, 8'(hostStandby));
    sendPkt(1'b1);
    waitLink(LS_L0S, 100, n);
    chk("idleCycles", 8'h01, 8'(n > `L0S_IDLE_CYC && n <= `L0S_IDLE_CYC + 4));
    hostOp(3, 2'h0, 8'h00);
    @(posedge clk);
    @(negedge clk);
    chk("rxTlp", 8'h01, 8'(rxTlp));
    waitLink(LS_L0, 8, n);
    waitLink(LS_L0S, 100, n);
    @(posedge clk);
    standbyEnable <= 1'b1;
    repeat (64) @(negedge clk);
    chk("hostStandby", 8'h01, 8'(hostStandby));
    chk("linkState", 8'(LS_L0S), 8'(linkState));
    @(posedge clk);
    pciActive <= 1'b1;
    @(posedge clk);
    pciActive <= 1'b0;
    waitLink(LS_L0, 8, n);
    chk("hostStandby", 8'h01, 8'(hostStandby));
    hostOp(0, `CFG_LNKCTL, 8'h00);
    standbyEnable <= 1'b0;
    repeat (90) @(negedge clk);
    chk("linkState", 8'(LS_L0), 8'(linkState));
  endtask
  task automatic d3Cycle;
    int n;
    hostOp(0, `CFG_PMCSR, 8'h03);
    repeat (3) @(negedge clk);
    chk("powerState", 8'(DS_D3HOT), 8'(powerState));
    chk("secClockEnable", 8'(`CLKOUT_ON), 8'(secClockEnable));
    chk("secBusReset_n", 8'h01, 8'(secBusReset_n));
    chk("busTxnAllowed", 8'h00, 8'(busTxnAllowed));
    waitLink(LS_L1, 40, n);
    chk("l1Seen", 8'h01, 8'(l1Seen));
    @(posedge clk);
    wakeReq_n <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!pmeSeen && n < 2200);
    chk("pmeInTime", 8'h01, 8'(pmeSeen && n <= 1020));
    chk("linkState", 8'(LS_L0), 8'(linkState));
    @(posedge clk);
    wakeReq_n <= 1'b1;
    waitLink(LS_L1, 40, n);
    readChk(`CFG_PMCSR, 8'h03, "pmcsr");
    hostOp(0, `CFG_PMCSR, 8'h00);
    repeat (3) @(negedge clk);
    chk("powerState", 8'(DS_D0_ACTIVE), 8'(powerState));
    readChk(`CFG_PMCSR, 8'h08, "pmcsr");
  endtask
  task automatic turnOff;
    int n;
    n = 0;
    hostOp(2, 2'h0, 8'h00);
    do begin
      @(negedge clk);
      n++;
    end while (!ackSeen && n < 40);
    chk("ackSeen", 8'h01, 8'(ackSeen));
    waitLink(LS_L23, 4, n);
    @(posedge clk);
    wakeReq_n <= 1'b0;
    txReq <= 1'b1;
    n = 0;
    repeat (2100) begin
      @(negedge clk);
      n += int'(pmeSeen | txTake);
    end
    chk("silentCount", 8'h00, 8'(n));
    chk("linkState", 8'(LS_L23), 8'(linkState));
    chk("busTxnAllowed", 8'h00, 8'(busTxnAllowed));
    @(posedge clk);
    wakeReq_n <= 1'b1;
    txReq <= 1'b0;
  endtask
  initial begin
    doReset();
    initCfg();
    standby();
    d3Cycle();
    turnOff();
    doReset();
    conclude();
  end
endmodule
